// File: design/ppm_edge_detect.sv
// Purpose: Chosen-edge detector for one port bit
// Assumes: Previous input sample is held by the caller
// Notes: Pure combinational, one instance per bonded bit
`timescale 1ns/1ps

module ppm_edge_detect (
    input wire logic cur, // Present input level
    input wire logic prev, // Level one cycle earlier
    input wire logic falling, // 1 selects the falling edge
    input wire logic armed, // Pin is bonded and in port mode
    output logic hit // Selected edge seen this cycle
);
    // ----------------------------------------------------------------
    // Edge select
    // ----------------------------------------------------------------
    // Rising or falling, gated by port mode
    assign hit = armed & (falling ? (prev & ~cur) : (~prev & cur));
endmodule : ppm_edge_detect

// File: design/ppm_top.sv
// Purpose: Pin-function multiplexer for an eight-bit port with AHB-Lite registers
// Assumes: Pin inputs are synchronous to hclk
// Notes: Bits 6 and 7 have no pin and serve as software interrupts
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ppm_params.svh"

// How it works
// - Pins 0 and 1 are port or peripheral only while LCD select is below 04h.
// - LCD select field below 04h keeps pins 0,1 as port; else LCD segments.
// - Pins 2 to 5 digital path works only while their analog-disable bit is zero.
// - Pin 0 function mode drives timer channel 2, input feeds capture 2A.
// - Pin 1 function mode takes direction from serial clock control; carries serial clock.
// - Pin 2 function mode forces input, feeds slave-transmit-enable, output low.
// - Pin 4 function mode forces output driven by serial transmit data.
// - Pin 5 function mode forces input routed to serial receive.
// - Pin 3 analog-disable asserts when supply-monitor level equals 1111b.
// - Bits 6,7 flags change only by software; enabled set flag interrupts.
module ppm_top
    import ppm_pkg::*;
(
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    output logic irq, // Level interrupt out
    output logic port_irq, // Port interrupt request
    input wire logic [5:0] pin_in, // Pin levels, bonded bits
    output logic [5:0] pin_out, // Pin drive levels
    output logic [5:0] pin_oe, // Pin output enables
    output logic [1:0] lcd_seg_en, // Pins 0,1 used as LCD segments
    input wire logic timer_ch2_output, // Timer compare 2 output
    output logic capture_ch2_input_a, // Capture 2 input A
    input wire logic serial_clock_dir_ctrl, // Serial clock direction, 1 out
    input wire logic serial_clock_line, // Serial clock out from unit
    output logic serial_clock_in, // Serial clock into unit
    output logic slave_transmit_enable, // Slave enable into unit
    input wire logic async_transmit_line, // Serial transmit data
    output logic async_receive_line // Serial receive into unit
);
    import ppm_pkg::*;

    ppm_state_type s_q;
    ppm_state_type s_d;
    logic [7:0] pin_in_bits;
    logic [7:0] edge_hit;
    logic [7:0] armed;
    logic [7:0] port_en;
    logic lcd_mode;
    logic [7:0] cap_eff;
    logic [7:0] pin_input_bits;

    // ----------------------------------------------------------------
    // Pin function decode
    // ----------------------------------------------------------------
    // LCD ownership of pins 0 and 1
    assign lcd_mode = (s_q.lcdp >= `PPM_LCDP_THRESH);

    // Effective analog disable per bit
    always_comb begin
        cap_eff = s_q.adis;
        cap_eff[1:0] = 2'h0;
        cap_eff[7:6] = 2'h0;
        cap_eff[3] = s_q.adis[3] | (s_q.svs == `PPM_SVS_EXT);
    end

    // Digital path enable per bonded bit
    always_comb begin
        port_en = 8'h00;
        port_en[1:0] = {2{~lcd_mode}};
        port_en[`PPM_ANALOG_HI:`PPM_ANALOG_LO] =
            ~cap_eff[`PPM_ANALOG_HI:`PPM_ANALOG_LO];
    end

    // Input register view, gated pins read low
    assign pin_in_bits = {2'h0, pin_in};
    assign pin_input_bits = pin_in_bits & port_en;

    // Edge interrupts only in plain port mode
    assign armed = port_en & ~s_q.sel;

    // One detector per bonded bit
    genvar gi;
    for (gi = 0; gi < `PPM_SW_LO; gi++) begin : g_edge
        ppm_edge_detect u_edge (
            .cur(pin_input_bits[gi]),
            .prev(s_q.in_prev[gi]),
            .falling(s_q.ies[gi]),
            .armed(armed[gi]),
            .hit(edge_hit[gi])
        );
    end
    assign edge_hit[7:6] = 2'h0;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] wmask;
        logic [7:0] rd8;
        logic [7:0] flags;
        logic [`PPM_EV_W-1:0] ev;
        logic [5:0] dout;
        logic [5:0] doe;
        logic dwrite;
        wmask = 8'h00;
        rd8 = 8'h00;
        flags = 8'h00;
        ev = '0;
        dout = 6'h00;
        doe = 6'h00;
        dwrite = 1'b0;
        s_d = s_q;

        // Address phase capture
        if (hready) begin
            s_d.a_valid = hsel & (htrans == `PPM_HTRANS_NONSEQ);
            s_d.a_write = hwrite;
            s_d.a_addr = haddr[`PPM_AW-1:0];
        end

        // Data phase write
        dwrite = s_q.a_valid & s_q.a_write;
        wmask = hwdata[7:0];
        if (dwrite) begin
            unique case (s_q.a_addr)
                `PPM_OFS_OUT: s_d.out = wmask;
                `PPM_OFS_DIR: s_d.dir = wmask;
                `PPM_OFS_IES: s_d.ies = wmask;
                `PPM_OFS_IE: s_d.ie = wmask;
                `PPM_OFS_SEL: s_d.sel = wmask;
                `PPM_OFS_ADIS: s_d.adis = wmask;
                `PPM_OFS_LCDP: s_d.lcdp = wmask[`PPM_LCDP_W-1:0];
                `PPM_OFS_SVS: s_d.svs = wmask[`PPM_SVS_W-1:0];
                `PPM_OFS_IMASK: s_d.imask = wmask[`PPM_EV_W-1:0];
                default: ;
            endcase
        end

        // Flag register: software write, then hardware edges win
        flags = s_q.ifg;
        if (dwrite && s_q.a_addr == `PPM_OFS_IFG) begin
            flags = wmask;
        end
        flags = flags | edge_hit;
        s_d.ifg = flags;
        s_d.in_prev = pin_input_bits;

        // Port request from enabled flags
        s_d.port_irq = |(s_d.ifg & s_d.ie);

        // Sticky status: set beats write-one-clear
        ev[`PPM_EV_PORT] = |(edge_hit & s_q.ie);
        ev[`PPM_EV_SW] = |(s_d.ifg[7:6] & s_d.ie[7:6] & ~(s_q.ifg[7:6] & s_q.ie[7:6]));
        s_d.istat = s_q.istat;
        if (dwrite && s_q.a_addr == `PPM_OFS_ISTAT) begin
            s_d.istat = s_q.istat & ~wmask[`PPM_EV_W-1:0];
        end
        s_d.istat = s_d.istat | ev;
        s_d.irq = |(s_d.istat & s_d.imask);

        // Read data for the next data phase
        if (hready && hsel && htrans == `PPM_HTRANS_NONSEQ && !hwrite) begin
            unique case (haddr[`PPM_AW-1:0])
                `PPM_OFS_IN: rd8 = pin_input_bits;
                `PPM_OFS_OUT: rd8 = s_d.out;
                `PPM_OFS_DIR: rd8 = s_d.dir;
                `PPM_OFS_IFG: rd8 = s_d.ifg;
                `PPM_OFS_IES: rd8 = s_d.ies;
                `PPM_OFS_IE: rd8 = s_d.ie;
                `PPM_OFS_SEL: rd8 = s_d.sel;
                `PPM_OFS_ADIS: rd8 = s_d.adis;
                `PPM_OFS_LCDP: rd8 = {5'h00, s_d.lcdp};
                `PPM_OFS_SVS: rd8 = {4'h0, s_d.svs};
                `PPM_OFS_ISTAT: rd8 = {6'h00, s_d.istat};
                `PPM_OFS_IMASK: rd8 = {6'h00, s_d.imask};
                default: rd8 = 8'h00;
            endcase
            s_d.hrdata = {24'h000000, rd8};
        end else if (hready) begin
            s_d.hrdata = 32'h00000000;
        end

        // Default port drive from direction and output bits
        dout = s_d.out[5:0];
        doe = s_d.dir[5:0];

        // Pin 0: timer compare out, capture in
        if (s_d.sel[0]) begin
            dout[0] = timer_ch2_output;
        end
        s_d.cap_ch2_a = s_d.sel[0] & pin_in[0] & ~lcd_mode;

        // Pin 1: serial clock, direction from serial unit
        if (s_d.sel[1]) begin
            doe[1] = serial_clock_dir_ctrl;
            dout[1] = serial_clock_line;
        end
        s_d.sclk_in = s_d.sel[1] & pin_in[1] & ~lcd_mode;

        // Pin 2: forced input to slave enable
        if (s_d.sel[2]) begin
            doe[2] = 1'b0;
            dout[2] = 1'b0;
        end
        s_d.ste_in = s_d.sel[2] & pin_in[2] & ~cap_eff[2];

        // Pin 3: no module function, low in select mode
        if (s_d.sel[3]) begin
            dout[3] = 1'b0;
        end

        // Pin 4: forced output with transmit data
        if (s_d.sel[4]) begin
            doe[4] = 1'b1;
            dout[4] = async_transmit_line;
        end

        // Pin 5: forced input to receive
        if (s_d.sel[5]) begin
            doe[5] = 1'b0;
            dout[5] = 1'b0;
        end
        s_d.rx_in = s_d.sel[5] & pin_in[5] & ~cap_eff[5];

        // Disabled digital paths float the pin
        doe = doe & port_en[5:0];
        dout = dout & port_en[5:0];
        s_d.pin_out = {2'h0, dout};
        s_d.pin_oe = {2'h0, doe};
        s_d.lcd_seg_en = {6'h00, {2{lcd_mode}}};
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops, except hreadyout and hresp which are tied constants
    assign hrdata = s_q.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = s_q.irq;
    assign port_irq = s_q.port_irq;
    assign pin_out = s_q.pin_out[5:0];
    assign pin_oe = s_q.pin_oe[5:0];
    assign lcd_seg_en = s_q.lcd_seg_en[1:0];
    assign capture_ch2_input_a = s_q.cap_ch2_a;
    assign serial_clock_in = s_q.sclk_in;
    assign slave_transmit_enable = s_q.ste_in;
    assign async_receive_line = s_q.rx_in;
endmodule : ppm_top

// File: inc/ppm_params.svh
// Purpose: Constants for the port pin function multiplexer
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes: Offsets are byte addresses
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPM_OFS_IN 12'h000
`define PPM_OFS_OUT 12'h004
`define PPM_OFS_DIR 12'h008
`define PPM_OFS_IFG 12'h00C
`define PPM_OFS_IES 12'h010
`define PPM_OFS_IE 12'h014
`define PPM_OFS_SEL 12'h018
`define PPM_OFS_ADIS 12'h01C
`define PPM_OFS_LCDP 12'h020
`define PPM_OFS_SVS 12'h024
`define PPM_OFS_ISTAT 12'h028
`define PPM_OFS_IMASK 12'h02C

// ----------------------------------------------------------------
// Field widths, thresholds and reset values
// ----------------------------------------------------------------
`define PPM_LCDP_W 3
`define PPM_LCDP_THRESH 3'h4
`define PPM_SVS_W 4
`define PPM_SVS_EXT 4'hF
`define PPM_ANALOG_LO 2
`define PPM_ANALOG_HI 5
`define PPM_SW_LO 6
`define PPM_PORT_RST 8'h00
`define PPM_EV_W 2
`define PPM_EV_PORT 0
`define PPM_EV_SW 1
`define PPM_HTRANS_NONSEQ 2'h2
`define PPM_AW 12

`endif

// File: inc/ppm_pkg.sv
// Purpose: Types for the port pin function multiplexer
// Assumes: Header of constants is included first
// Notes: State of the top module is one packed struct
`include "ppm_params.svh"

package ppm_pkg;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] dir;
        logic [7:0] ifg;
        logic [7:0] ies;
        logic [7:0] ie;
        logic [7:0] sel;
        logic [7:0] adis;
        logic [`PPM_LCDP_W-1:0] lcdp;
        logic [`PPM_SVS_W-1:0] svs;
        logic [`PPM_EV_W-1:0] istat;
        logic [`PPM_EV_W-1:0] imask;
        logic [7:0] in_prev;
        logic a_valid;
        logic a_write;
        logic [`PPM_AW-1:0] a_addr;
        logic [31:0] hrdata;
        logic irq;
        logic port_irq;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] lcd_seg_en;
        logic cap_ch2_a;
        logic sclk_in;
        logic ste_in;
        logic rx_in;
    } ppm_state_type;

endpackage : ppm_pkg

// File: sim/ppm_board.sv
// Purpose: Board levels on the port pins
// Assumes: Board drives every pin weakly
// Notes: Device drive wins where enabled
`timescale 1ns/1ps
module ppm_board (
    input wire logic [5:0] drive_level, // Board level
    input wire logic [5:0] pin_out, // Device drive
    input wire logic [5:0] pin_oe, // Device enables
    output logic [5:0] pin_in // Resolved level
);
    // Resolve each pin
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drive_level[i];
        end
    end
endmodule : ppm_board

// File: sim/ppm_top_sva.sv
// Purpose: Port checks for the pin mux
// Assumes: Bound to ppm_top
// Notes: Sees top ports only
`timescale 1ns/1ps
module ppm_chk (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic hsel, // Select
    input wire logic [1:0] htrans, // Type
    input wire logic hwrite, // Write
    input wire logic hready, // Ready in
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Ready out
    input wire logic hresp, // Response
    input wire logic [5:0] pin_in, // Pins
    input wire logic [5:0] pin_out, // Drive
    input wire logic [5:0] pin_oe, // Enables
    input wire logic [1:0] lcd_seg_en, // LCD use
    input wire logic capture_ch2_input_a, // Capture
    input wire logic serial_clock_in, // Clock in
    input wire logic slave_transmit_enable, // Slave enable
    input wire logic async_receive_line // Receive
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // -----------------------------
    // Bus and pin relations
    // -----------------------------
    sequence s_rd_req;
        hsel && hready && htrans == 2'h2 && !hwrite;
    endsequence
    sequence s_lcd_held;
        lcd_seg_en[0] && $past(lcd_seg_en[0]);
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_rdata_quiet: assert property (!(hsel && hready && htrans == 2'h2 && !hwrite)
        |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    a_capture_pin: assert property (capture_ch2_input_a |-> $past(pin_in[0]))
        else $error("capture high without pin");
    a_sclk_pin: assert property (serial_clock_in |-> $past(pin_in[1]))
        else $error("serial clock in without pin");
    a_ste_input: assert property (slave_transmit_enable && $past(slave_transmit_enable)
        |-> !pin_oe[2] && !pin_out[2] && $past(pin_in[2]))
        else $error("slave enable pin driven");
    a_rx_input: assert property (async_receive_line && $past(async_receive_line)
        |-> !pin_oe[5] && $past(pin_in[5]))
        else $error("receive pin driven");
    a_lcd_pair: assert property (lcd_seg_en[0] == lcd_seg_en[1])
        else $error("lcd pins differ");
    a_lcd_no_func: assert property (s_lcd_held
        |-> !capture_ch2_input_a && !serial_clock_in)
        else $error("peripheral input in lcd mode");
endmodule : ppm_chk
bind ppm_top ppm_chk ppm_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .lcd_seg_en(lcd_seg_en), .capture_ch2_input_a(capture_ch2_input_a),
    .serial_clock_in(serial_clock_in), .slave_transmit_enable(slave_transmit_enable),
    .async_receive_line(async_receive_line));

// File: sim/ppm_top_tb.sv
// Purpose: Self-checking bench for the pin mux
// Assumes: Slave answers with hreadyout
// Notes: Outputs settle two cycles after a write
`timescale 1ns/1ps
`include "ppm_params.svh"
module ppm_top_tb;
    // -----------------------------
    // Signals
    // -----------------------------
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic sdir = 0, sline = 0, tx = 0, t2 = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [1:0] htrans = 0, lcd;
    logic [2:0] hsize = 3'h2;
    logic [5:0] ext = 0, pin_in, pin_out, pin_oe;
    logic hreadyout, hresp, irq, port_irq, cap, sin, ste, rx;
    int mismatches = 0;
    int total_checks = 0;
    assign hready = hreadyout;
    // Clock
    always #12.5 hclk = ~hclk;
    ppm_top ppm_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .port_irq(port_irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .lcd_seg_en(lcd), .timer_ch2_output(t2), .capture_ch2_input_a(cap),
        .serial_clock_dir_ctrl(sdir), .serial_clock_line(sline), .serial_clock_in(sin),
        .slave_transmit_enable(ste), .async_transmit_line(tx), .async_receive_line(rx));
    ppm_board ppm_board_inst (.drive_level(ext), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));
    // -----------------------------
    // Bus tasks and checks
    // -----------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        hsel <= 1'h1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'h1;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h0, v};
        do @(posedge hclk); while (hready !== 1'h1);
        repeat (2) @(posedge hclk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        hsel <= 1'h1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        d = hrdata;
        chk(n, e, d);
    endtask : rd
    task automatic drv(input logic [5:0] v);
        ext <= v;
        repeat (4) @(posedge hclk);
    endtask : drv
    // -----------------------------
    // Scenarios
    // -----------------------------
    task automatic t_regs;
        rd(`PPM_OFS_OUT, 32'h0, "out reset");
        wr(`PPM_OFS_OUT, 8'hA5);
        rd(`PPM_OFS_OUT, 32'hA5, "out");
        wr(12'h0FC, 8'hFF);
        rd(12'h0FC, 32'h0, "unmapped");
    endtask : t_regs
    task automatic t_lcd;
        t2 <= 1'h1;
        wr(`PPM_OFS_SEL, 8'h01);
        wr(`PPM_OFS_DIR, 8'h01);
        chk("pin0 oe out", 32'h1, pin_oe[0] & pin_out[0]);
        wr(`PPM_OFS_DIR, 8'h00);
        drv(6'h01);
        chk("capture", 32'h1, cap);
        wr(`PPM_OFS_LCDP, 8'h03);
        chk("lcd at 3", 32'h0, lcd);
        chk("capture at 3", 32'h1, cap);
        wr(`PPM_OFS_LCDP, 8'h04);
        chk("lcd at 4", 32'h3, lcd);
        chk("capture at 4", 32'h0, cap);
        wr(`PPM_OFS_LCDP, 8'h00);
    endtask : t_lcd
    task automatic t_sclk;
        sdir <= 1'h1;
        sline <= 1'h1;
        wr(`PPM_OFS_SEL, 8'h02);
        drv(6'h00);
        chk("sclk drive", 32'h1, pin_oe[1] & pin_out[1]);
        sdir <= 1'h0;
        wr(`PPM_OFS_DIR, 8'h02);
        drv(6'h02);
        chk("sclk oe", 32'h0, pin_oe[1]);
        chk("sclk in", 32'h1, sin);
    endtask : t_sclk
    task automatic t_serial;
        tx <= 1'h1;
        wr(`PPM_OFS_DIR, 8'h24);
        wr(`PPM_OFS_SEL, 8'h34);
        drv(6'h24);
        chk("serial oe", 32'h10, pin_oe & 6'h34);
        chk("ste rx tx", 32'h7, {ste, rx, pin_out[4]});
        tx <= 1'h0;
        drv(6'h24);
        chk("tx low", 32'h0, pin_out[4]);
        wr(`PPM_OFS_ADIS, 8'h30);
        chk("analog off", 32'h0, {pin_oe[4], rx});
        wr(`PPM_OFS_ADIS, 8'h00);
        wr(`PPM_OFS_SEL, 8'h00);
        wr(`PPM_OFS_OUT, 8'h08);
        wr(`PPM_OFS_DIR, 8'h08);
        chk("pin3 on", 32'h1, pin_oe[3]);
        wr(`PPM_OFS_SVS, 8'h0F);
        chk("pin3 analog", 32'h0, pin_oe[3]);
        wr(`PPM_OFS_SVS, 8'h0E);
        chk("pin3 back", 32'h1, pin_oe[3]);
        wr(`PPM_OFS_SVS, 8'h00);
    endtask : t_serial
    task automatic t_irq;
        wr(`PPM_OFS_DIR, 8'h00);
        drv(6'h00);
        wr(`PPM_OFS_IFG, 8'h00);
        wr(`PPM_OFS_ISTAT, 8'h03);
        wr(`PPM_OFS_IES, 8'h02);
        wr(`PPM_OFS_IE, 8'h03);
        wr(`PPM_OFS_IMASK, 8'h01);
        drv(6'h02);
        rd(`PPM_OFS_IFG, 32'h0, "wrong edge");
        drv(6'h01);
        rd(`PPM_OFS_IFG, 32'h3, "edge flags");
        chk("irq pair", 32'h3, {port_irq, irq});
        wr(`PPM_OFS_IMASK, 8'h00);
        chk("irq masked", 32'h0, irq);
        wr(`PPM_OFS_ISTAT, 8'h03);
        wr(`PPM_OFS_IMASK, 8'h01);
        chk("irq cleared", 32'h0, irq);
        wr(`PPM_OFS_IE, 8'h40);
        drv(6'h3F);
        drv(6'h00);
        rd(`PPM_OFS_IFG, 32'h3F, "hw flags");
        wr(`PPM_OFS_IFG, 8'h40);
        chk("sw irq", 32'h1, port_irq);
        wr(`PPM_OFS_IE, 8'h80);
        chk("sw irq off", 32'h0, port_irq);
    endtask : t_irq
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // Main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_regs;
        t_lcd;
        t_sclk;
        t_serial;
        t_irq;
        give_verdict;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        give_verdict;
    end
endmodule : ppm_top_tb
